// file: dfpc_regs.sv
// Register bank for digital frequency pulling with output gating
//
// Contract
// - Power-up: nominal frequency, factory pull span, before any write.
// - Pull span and offset are writable after power-up.
// - Offset is 26-bit two's complement, scaled by current span.
// - Offset resets to zero, meaning nominal frequency.
// - Low 16 bits at 0x00[15:0], upper 10 at 0x01[9:0].
// - Frequency change starts only on upper register write.
// - Span select is 4-bit field 0x02[3:0], sixteen codes.
// - Output change stays inside selected pull span.
// - Step size follows span; analog side realises resolution.
// - Enable bit 0x01[10] drives output only under software control.
// - Under pin control, enable bit writes do not affect output.
// - Span, offset and enable are set by serial register writes.
// - Unused upper bits of 0x01 and 0x02 read zero, ignore writes.
// - Software enable defaults to 0, output disabled.
`timescale 1ns/1ps
`default_nettype none
module dfpc_regs
	import dfpc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Register access from the serial front end
	input  wire dfpc_req_s  req,
	output var  dfpc_rsp_s  rsp,
	// Configuration straps and pin enable
	input  wire logic [3:0] factory_span,
	input  wire logic       sw_oe_mode,
	input  wire logic       oe_pin,
	// Control to the fractional divider and output driver
	output var  dfpc_ctrl_s ctrl,
	output logic            out_enable,
	output logic            update_too_fast
);

	// Offset path
	logic [15:0] low_shadow_r, low_shadow_nxt;
	logic [25:0] offset_r, offset_nxt;
	logic [9:0]  high_r, high_nxt;
	logic        oe_bit_r, oe_bit_nxt;
	logic        update_r, update_nxt;
	// Span path
	logic [3:0]  span_r, span_nxt;
	logic        strap_done_r, strap_done_nxt;
	// Output gating
	logic        out_en_r, out_en_nxt;
	// Read response
	dfpc_rsp_s   rsp_r, rsp_nxt;
	// Update spacing monitor
	logic [9:0]  gap_cnt_r, gap_cnt_nxt;
	logic        fast_r, fast_nxt;
	// Decoded write strobes
	logic        wr_ok;
	logic        wr_low;
	logic        wr_high;
	logic        wr_span;

	function automatic logic hit(input dfpc_req_s r, input logic [1:0] a);
		hit = r.addr == a;
	endfunction

	// Write decode; nothing lands before the span strap is caught
	always_comb
	begin
		wr_ok   = req.wr && strap_done_r;
		wr_low  = 1'b0;
		wr_high = 1'b0;
		wr_span = 1'b0;
		if (wr_ok)
		begin
			if (hit(req, ADDR_OFS_LOW))
			begin
				wr_low = 1'b1;
			end
			else if (hit(req, ADDR_OFS_HIGH))
			begin
				wr_high = 1'b1;
			end
			else if (hit(req, ADDR_PULL_SPAN))
			begin
				wr_span = 1'b1;
			end
		end
	end

	always_comb
	begin
		low_shadow_nxt = low_shadow_r;
		high_nxt       = high_r;
		oe_bit_nxt     = oe_bit_r;
		offset_nxt     = offset_r;
		update_nxt     = 1'b0;
		if (wr_low)
		begin
			low_shadow_nxt = req.wdata;
		end
		if (wr_high)
		begin
			high_nxt   = req.wdata[HIGH_LSB +: HIGH_WIDTH];
			oe_bit_nxt = req.wdata[OE_BIT];
			// Whole word moves in one step so the divider never sees a half
			offset_nxt = {req.wdata[HIGH_LSB +: HIGH_WIDTH], low_shadow_r};
			update_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			low_shadow_r <= OFS_RESET[15:0];
			high_r       <= OFS_RESET[25:16];
			oe_bit_r     <= OE_RESET;
			offset_r     <= OFS_RESET;
			update_r     <= 1'b0;
		end
		else
		begin
			low_shadow_r <= low_shadow_nxt;
			high_r       <= high_nxt;
			oe_bit_r     <= oe_bit_nxt;
			offset_r     <= offset_nxt;
			update_r     <= update_nxt;
		end
	end

	always_comb
	begin
		span_nxt       = span_r;
		strap_done_nxt = 1'b1;
		// Strap caught once after release, never under reset
		if (!strap_done_r)
		begin
			span_nxt = factory_span;
		end
		else if (wr_span)
		begin
			span_nxt = req.wdata[SPAN_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			span_r       <= SPAN_RESET;
			strap_done_r <= 1'b0;
		end
		else
		begin
			span_r       <= span_nxt;
			strap_done_r <= strap_done_nxt;
		end
	end

	always_comb
	begin
		// Pin control ignores the software bit entirely
		out_en_nxt = sw_oe_mode ? oe_bit_nxt : oe_pin;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_en_r <= 1'b0;
		end
		else
		begin
			out_en_r <= out_en_nxt;
		end
	end

	always_comb
	begin
		rsp_nxt        = '0;
		rsp_nxt.rvalid = req.rd;
		// Data bus stays at zero outside a read so stale words never show
		if (req.rd)
		begin
			if (hit(req, ADDR_OFS_LOW))
			begin
				rsp_nxt.rdata = low_shadow_r;
			end
			else if (hit(req, ADDR_OFS_HIGH))
			begin
				rsp_nxt.rdata = {5'h00, oe_bit_r, high_r};
			end
			else if (hit(req, ADDR_PULL_SPAN))
			begin
				rsp_nxt.rdata = {12'h000, span_r};
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rsp_r <= '0;
		end
		else
		begin
			rsp_r <= rsp_nxt;
		end
	end

	always_comb
	begin
		fast_nxt    = 1'b0;
		gap_cnt_nxt = gap_cnt_r;
		if (gap_cnt_r != 10'h000)
		begin
			gap_cnt_nxt = gap_cnt_r - 10'h001;
		end
		if (wr_high)
		begin
			// Flag only: the word is still applied, pacing is the controller's job
			fast_nxt    = (gap_cnt_r != 10'h000);
			gap_cnt_nxt = 10'(UPDATE_GAP_CYC - 1);
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gap_cnt_r <= 10'h000;
			fast_r    <= 1'b0;
		end
		else
		begin
			gap_cnt_r <= gap_cnt_nxt;
			fast_r    <= fast_nxt;
		end
	end

	// Signed word is a fraction of the span, so any value stays inside it
	assign ctrl.offset     = offset_r;
	assign ctrl.span       = span_r;
	assign ctrl.oe         = oe_bit_r;
	assign ctrl.update     = update_r;
	assign out_enable      = out_en_r;
	assign rsp             = rsp_r;
	// Flags controller updates closer than the allowed spacing
	assign update_too_fast = fast_r;
endmodule
`default_nettype wire

// file: dfpc_pkg.sv
// Package for the digital frequency pull control register bank
package dfpc_pkg;
	localparam logic [1:0]  ADDR_OFS_LOW     = 2'h0;
	localparam logic [1:0]  ADDR_OFS_HIGH    = 2'h1;
	localparam logic [1:0]  ADDR_PULL_SPAN   = 2'h2;
	localparam int          OFS_WIDTH        = 26;
	localparam int          LOW_WIDTH        = 16;
	localparam int          HIGH_WIDTH       = 10;
	localparam int          HIGH_LSB         = 0;
	localparam int          OE_BIT           = 10;
	localparam int          SPAN_WIDTH       = 4;
	localparam logic [25:0] OFS_RESET        = 26'h0000000;
	localparam logic        OE_RESET         = 1'b0;
	localparam logic [3:0]  SPAN_RESET       = 4'h0;
	// Fastest update rate the controller may use, and its cycle spacing
	localparam int          CLK_HZ           = 25000000;
	localparam int          UPDATE_MAX_HZ    = 38000;
	localparam int          UPDATE_GAP_CYC   = (CLK_HZ + UPDATE_MAX_HZ - 1) / UPDATE_MAX_HZ;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [1:0]  addr;
		logic [15:0] wdata;
	} dfpc_req_s;

	typedef struct packed {
		logic        rvalid;
		logic [15:0] rdata;
	} dfpc_rsp_s;

	typedef struct packed {
		logic [25:0] offset;
		logic [3:0]  span;
		logic        oe;
		logic        update;
	} dfpc_ctrl_s;
endpackage

// file: dfpc_properties.sv
// Checker for the pull control register bank
`timescale 1ns/1ps
`default_nettype none
module dfpc_properties
	import dfpc_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Watched ports
	input wire dfpc_req_s  req,
	input wire logic       sw_oe_mode,
	input wire logic       oe_pin,
	input wire dfpc_rsp_s  rsp,
	input wire dfpc_ctrl_s ctrl,
	input wire logic       out_enable,
	input wire logic       update_too_fast
);
	logic live_r;
	wire  hw = live_r && req.wr && req.addr == ADDR_OFS_HIGH;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// First cycle after release refuses writes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			live_r <= 1'b0;
		else
			live_r <= 1'b1;
	end
	upd_on_high_a: assert property (hw |=> ctrl.update) else $error("no update");
	high_half_a: assert property (hw |=> ctrl.offset[25:16] == $past(req.wdata[9:0]))
		else $error("bad high");
	oe_load_a: assert property (hw |=> ctrl.oe == $past(req.wdata[10])) else $error("bad oe");
	offset_hold_a: assert property (!ctrl.update |-> $stable(ctrl.offset))
		else $error("offset moved");
	span_load_a: assert property (live_r && req.wr && req.addr == ADDR_PULL_SPAN |=>
		ctrl.span == $past(req.wdata[3:0])) else $error("bad span");
	read_idle_a: assert property (!rsp.rvalid |-> rsp.rdata == 16'h0000) else $error("stray");
	pin_oe_a: assert property (live_r && !$past(sw_oe_mode) |->
		out_enable == $past(oe_pin)) else $error("pin oe");
	sw_oe_a: assert property (live_r && $past(sw_oe_mode) |-> out_enable == ctrl.oe)
		else $error("sw oe");
	cover property (hw);
	cover property (update_too_fast);
	cover property (rsp.rvalid);
endmodule
bind dfpc_regs dfpc_properties dfpc_properties_inst (.*);
`default_nettype wire

// file: dfpc_host.sv
// Register bus master model
`timescale 1ns/1ps
`default_nettype none
module dfpc_host
	import dfpc_pkg::*;
(
	// Bus
	input wire logic      clk,
	output var dfpc_req_s req
);
	initial req = '0;
	task automatic go(input logic w, input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{w, !w, a, d};
		@(posedge clk);
		// Released data scrambled so stale words cannot pass
		req <= '{1'b0, 1'b0, a, ~d};
		#1;
	endtask
endmodule
`default_nettype wire

// file: dfpc_tb_top.sv
// Bench for the pull control register bank
`timescale 1ns/1ps
`default_nettype none
module dfpc_tb_top;
	import dfpc_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       mode = 1'b0;
	logic       pin = 1'b0;
	logic [3:0] fs = 4'h0;
	dfpc_req_s  req;
	dfpc_rsp_s  rsp;
	dfpc_ctrl_s c;
	logic       oe;
	logic       fast;
	int         n_errors = 0;
	int         tests_run = 0;
	int         w, n, h;
	// Reference model of the register contents, kept from the rules
	int         m_low = 0;
	int         m_high = 0;
	int         m_oe = 0;
	int         m_span = 0;
	int         m_ofs = 0;
	int         exp_q[$];
	always #20 clk = ~clk;
	dfpc_regs dfpc_regs_inst (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .factory_span(fs),
		.sw_oe_mode(mode), .oe_pin(pin), .ctrl(c), .out_enable(oe), .update_too_fast(fast));
	dfpc_host dfpc_host_inst (.clk(clk), .req(req));
	task automatic chk(input string s, input logic [25:0] v, input logic [25:0] e);
		tests_run++;
		if (v !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic put(input logic [1:0] a, input logic [15:0] d);
		dfpc_host_inst.go(1'b1, a, d);
		if (a == ADDR_OFS_LOW)
			m_low = d;
		else if (a == ADDR_OFS_HIGH)
		begin
			m_high = d[9:0];
			m_oe   = d[10];
			m_ofs  = m_high * 65536 + m_low;
		end
		else if (a == ADDR_PULL_SPAN)
			m_span = d[3:0];
	endtask
	task automatic get(input logic [1:0] a);
		if (a == ADDR_OFS_LOW)
			exp_q.push_back(m_low);
		else if (a == ADDR_OFS_HIGH)
			exp_q.push_back(m_oe * 1024 + m_high);
		else if (a == ADDR_PULL_SPAN)
			exp_q.push_back(m_span);
		else
			exp_q.push_back(0);
		dfpc_host_inst.go(1'b0, a, 16'h0000);
		chk("rv", rsp.rvalid, 1);
		chk("rd", rsp.rdata, exp_q.pop_front());
	endtask
	initial
	begin
		#1ms;
		n_errors++;
		conclude();
	end
	initial
	begin
		void'($urandom(27269));
		h = $urandom;
		fs <= h[3:0];
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		m_span = h[3:0];
		chk("ofs", c.offset, m_ofs);
		chk("oe", c.oe, m_oe);
		chk("span", c.span, m_span);
		chk("pin", oe, pin);
		for (int i = 0; i < 8; i++)
		begin
			h = $urandom;
			n = $urandom;
			@(posedge clk);
			mode <= i[0];
			pin <= h[12];
			put(ADDR_PULL_SPAN, h[31:16]);
			chk("span", c.span, m_span);
			put(ADDR_OFS_LOW, n[15:0]);
			chk("hold", c.offset, m_ofs);
			repeat (UPDATE_GAP_CYC) @(posedge clk);
			put(ADDR_OFS_HIGH, {h[15:10], n[25:16]});
			w = n[25:0];
			chk("ofs", c.offset, w);
			chk("model", c.offset, m_ofs);
			chk("upd", c.update, 1);
			chk("oe", oe, mode ? m_oe : pin);
			for (int a = 0; a < 4; a++)
			begin
				get(a[1:0]);
			end
		end
		put(ADDR_OFS_HIGH, 16'hFFFF);
		chk("fast", fast, 1);
		chk("ofs", c.offset, {10'h3FF, n[15:0]});
		get(ADDR_OFS_HIGH);
		repeat (UPDATE_GAP_CYC) @(posedge clk);
		w = -((50 * 33554431 + 100) / 200);
		put(ADDR_OFS_LOW, w[15:0]);
		put(ADDR_OFS_HIGH, {6'h01, w[25:16]});
		chk("signed", c.offset, w[25:0]);
		chk("fast", fast, 0);
		chk("oe", c.oe, 1);
		conclude();
	end
endmodule
`default_nettype wire
